// *** verilog/ext_irq_pkg.sv ***
/*
  Constants for the external interrupt latch: register offsets, bit positions,
  reset values and timing counts.
  Assumes a 32-bit APB slave, one register per aligned word.
*/
package ext_irq_pkg;
  // byte offsets on the APB bus
  localparam logic [7:0] STATUS_CONTROL_OFFSET = 8'h18;
  localparam logic [7:0] OPTION_CONTROL_OFFSET = 8'h1C;
  localparam logic [7:0] SYSTEM_CONTROL_OFFSET = 8'h20;
  // status and control register fields
  localparam int MODE_BIT = 0;
  localparam int MASK_BIT = 1;
  localparam int ACK_BIT = 2;
  localparam int PENDING_BIT = 3;
  // option control register fields
  localparam int PULLUP_DISABLE_BIT = 0;
  localparam int SHARED_ENABLE_BIT = 1;
  localparam int SHARED_FLAG_BIT = 2;
  // system control register fields (usb enable, break clear enable)
  localparam int USB_ENABLE_BIT = 0;
  localparam int BREAK_CLEAR_BIT = 1;
  // values after reset
  localparam logic RESET_MODE = 1'b0;
  localparam logic RESET_MASK = 1'b0;
  localparam logic RESET_LATCH = 1'b0;
  localparam logic RESET_OPTION_BIT = 1'b0;
  localparam logic RESET_BREAK_CLEAR = 1'b0;
  localparam logic [2:0] RESET_SYNC = 3'b111;
  // cpu vector pair for this source
  localparam logic [15:0] VECTOR_HIGH_ADDR = 16'hFFF8;
  localparam logic [15:0] VECTOR_LOW_ADDR = 16'hFFF9;
  // apb answer latency in cycles after setup
  localparam int APB_WAIT_CYCLES = 0;
endpackage

// *** verilog/external_irq_latch.sv ***
/*
  External interrupt latch: dedicated active-low pin plus a shared port pin,
  edge or edge-and-level sensitivity, mask, acknowledge by vector fetch or
  software, break-state protection. Registers reached over APB.
  Assumes the cpu gives a one-cycle vector fetch strobe and a break level,
  both on clk_in; pins are asynchronous.
*/
// How it works
// - a low on the dedicated pin sets the request latch per sensitivity.
// - a vector fetch strobe clears the request latch.
// - writing one to the acknowledge bit clears the request latch.
// - reset clears latch and sensitivity bit even with pin low.
// - sensitivity clear: falling edges only, acknowledge clears at once.
// - sensitivity set: pending until acknowledged and pin high, any order.
// - acknowledge leaves edge detection alone; later edges latch anew.
// - unmasked service takes its vector from FFF8 and FFF9.
// - mask set withholds the latched request from the cpu.
// - pending flag shows the latch regardless of the mask.
// - dedicated pin pullup is on unless the pullup disable bit is set.
// - shared pin is a source only with usb off and its enable set.
// - shared enable forces the shared pin to input with pullup.
// - shared source is ORed with the dedicated pin into one latch.
// - a shared pin interrupt also sets the shared flag.
// - with break clear enabled, break-state clears stick afterwards.
// - with break clear disabled, software acknowledges in break do nothing; a vector fetch still clears.
// - acknowledge bit is write-only and reads zero.
// - shared flag is read-only, set on edges, cleared by option read.
// - writing one to mask disables requests; reset clears mask.
module external_irq_latch
  import ext_irq_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // pins
  input wire logic irq_n_in,
  input wire logic shared_port_pin_in,
  // cpu side
  input wire logic vector_fetch_in,
  input wire logic break_state_in,
  output logic irq_request_out,
  output logic [15:0] vector_addr_out,
  // pad controls
  output logic irq_pullup_out,
  output logic shared_pin_force_input_out,
  output logic shared_pin_pullup_out
);

  logic [2:0] irq_sync;
  logic [2:0] shared_sync;
  logic irq_level;
  logic shared_level;
  logic irq_prev;
  logic shared_prev;
  logic mode;
  logic unit_mask_bit;
  logic irq_latch;
  logic pending_flag;
  logic pin_pullup_disable;
  logic shared_pin_irq_enable;
  logic shared_pin_irq_flag;
  logic usb_function_enable;
  logic break_clear_enable;
  logic shared_active;
  logic irq_edge;
  logic shared_edge;
  logic source_low;
  logic any_edge;
  logic wr_access;
  logic rd_access;
  logic ack_write;
  logic ack_event;
  logic next_latch;

  function automatic logic falling(input logic prev, input logic now);
    falling = prev & ~now;
  endfunction

  // stages two and three both low: the pin has been low for two samples
  function automatic logic settled_low(input logic [2:0] stages);
    settled_low = (stages[2:1] == 2'b00);
  endfunction

  // three-stage synchroniser, kept out of reset so it tracks the pins throughout
  always_ff @(posedge clk_in) begin
    irq_sync <= {irq_sync[1:0], irq_n_in};
  end

  always_ff @(posedge clk_in) begin
    shared_sync <= {shared_sync[1:0], shared_port_pin_in};
  end

  // change accepted only once stages two and three agree
  // a pin held low through reset is taken as its level, not as a new edge
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_level <= ~settled_low(irq_sync);
      irq_prev <= ~settled_low(irq_sync);
    end else begin
      if (irq_sync[1] == irq_sync[2]) begin
        irq_level <= irq_sync[2];
      end
      irq_prev <= irq_level;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      shared_level <= ~settled_low(shared_sync);
      shared_prev <= ~settled_low(shared_sync);
    end else begin
      if (shared_sync[1] == shared_sync[2]) begin
        shared_level <= shared_sync[2];
      end
      shared_prev <= shared_level;
    end
  end

  assign shared_active = shared_pin_irq_enable & ~usb_function_enable;
  assign irq_edge = falling(irq_prev, irq_level);
  assign shared_edge = shared_active & falling(shared_prev, shared_level);
  assign any_edge = irq_edge | shared_edge;
  assign source_low = ~irq_level | (shared_active & ~shared_level);

  assign wr_access = psel_in & penable_in & pwrite_in;
  assign rd_access = psel_in & penable_in & ~pwrite_in;
  assign ack_write = wr_access & (paddr_in == STATUS_CONTROL_OFFSET) & pwdata_in[ACK_BIT];

  // break protects the latch from software acknowledge unless break clear is enabled; vector fetch always clears
  // clear in break sticks, latch has no shadow copy
  assign ack_event = vector_fetch_in | (ack_write & (~break_state_in | break_clear_enable));

  // the latch holds edges only; the level term is added on the way out, so an
  // acknowledge taken while the pin is low still counts once the pin goes high
  // pending until acknowledged and source high, either order
  assign pending_flag = irq_latch | (mode & source_low);

  // set wins over acknowledge in the same cycle, so no edge is lost
  always_comb begin
    next_latch = irq_latch;
    if (ack_event) begin
      next_latch = 1'b0;
    end
    // falling edge on either source pin sets the latch
    // edge detection runs regardless of acknowledge
    if (any_edge) begin
      next_latch = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_latch <= RESET_LATCH;
    end else begin
      irq_latch <= next_latch;
    end
  end

  // status and control register
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mode <= RESET_MODE;
      unit_mask_bit <= RESET_MASK;
    end else if (wr_access && paddr_in == STATUS_CONTROL_OFFSET) begin
      mode <= pwdata_in[MODE_BIT];
      unit_mask_bit <= pwdata_in[MASK_BIT];
    end
  end

  // option control register
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pin_pullup_disable <= RESET_OPTION_BIT;
      shared_pin_irq_enable <= RESET_OPTION_BIT;
    end else if (wr_access && paddr_in == OPTION_CONTROL_OFFSET) begin
      pin_pullup_disable <= pwdata_in[PULLUP_DISABLE_BIT];
      shared_pin_irq_enable <= pwdata_in[SHARED_ENABLE_BIT];
    end
  end

  // system control register: usb enable and break clear enable belong to other
  // units; kept here so the block can be driven on its own
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      usb_function_enable <= RESET_OPTION_BIT;
      break_clear_enable <= RESET_BREAK_CLEAR;
    end else if (wr_access && paddr_in == SYSTEM_CONTROL_OFFSET) begin
      usb_function_enable <= pwdata_in[USB_ENABLE_BIT];
      break_clear_enable <= pwdata_in[BREAK_CLEAR_BIT];
    end
  end

  // read of option register clears it, a new edge wins
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      shared_pin_irq_flag <= RESET_OPTION_BIT;
    end else if (shared_edge) begin
      shared_pin_irq_flag <= 1'b1;
    end else if (rd_access && paddr_in == OPTION_CONTROL_OFFSET) begin
      shared_pin_irq_flag <= 1'b0;
    end
  end

  // read data; zero-wait slave, unmapped reads return zero without error
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      prdata_out <= '0;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= '0;
      case (paddr_in)
        STATUS_CONTROL_OFFSET: begin
          prdata_out[PENDING_BIT] <= pending_flag;
          prdata_out[MASK_BIT] <= unit_mask_bit;
          prdata_out[MODE_BIT] <= mode;
        end
        OPTION_CONTROL_OFFSET: begin
          prdata_out[SHARED_FLAG_BIT] <= shared_pin_irq_flag;
          prdata_out[SHARED_ENABLE_BIT] <= shared_pin_irq_enable;
          prdata_out[PULLUP_DISABLE_BIT] <= pin_pullup_disable;
        end
        SYSTEM_CONTROL_OFFSET: begin
          prdata_out[BREAK_CLEAR_BIT] <= break_clear_enable;
          prdata_out[USB_ENABLE_BIT] <= usb_function_enable;
        end
        default: begin
          prdata_out <= '0;
        end
      endcase
    end
  end

  // zero-wait answer: ready in the first access cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
    end
  end

  // no access can fail: unmapped reads give zero, unmapped writes are dropped
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_request_out <= 1'b0;
    end else begin
      irq_request_out <= (next_latch | (mode & source_low)) & ~unit_mask_bit;
    end
  end

  // vector pair, high byte address given
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      vector_addr_out <= VECTOR_HIGH_ADDR;
    end else begin
      vector_addr_out <= VECTOR_HIGH_ADDR;
    end
  end

  // pad controls
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_pullup_out <= 1'b1;
      shared_pin_force_input_out <= 1'b0;
      shared_pin_pullup_out <= 1'b0;
    end else begin
      irq_pullup_out <= ~pin_pullup_disable;
      // shared enable forces input with pullup
      shared_pin_force_input_out <= shared_pin_irq_enable;
      shared_pin_pullup_out <= shared_pin_irq_enable;
    end
  end

endmodule

// *** verification/external_irq_latch_checker.sv ***
/* assertions on the external_irq_latch ports: apb answer, mask, reset, pads
   assumes one clock and a bind to the design top */
module external_irq_latch_checker
  import ext_irq_pkg::*;
(
  // clock, reset and apb
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // cpu side and pads
  input wire logic irq_request_out,
  input wire logic [15:0] vector_addr_out,
  input wire logic irq_pullup_out,
  input wire logic shared_pin_force_input_out,
  input wire logic shared_pin_pullup_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire acc = psel_in && penable_in && pready_out;
  chk_ready_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no answer after setup");
  chk_no_slverr: assert property (!pslverr_out) else $error("slave error raised");
  chk_vector_pair: assert property (vector_addr_out == VECTOR_HIGH_ADDR)
    else $error("vector address wrong");
  chk_shared_pad: assert property (shared_pin_force_input_out == shared_pin_pullup_out)
    else $error("shared pad controls differ");
  chk_ack_reads_zero: assert property (acc && !pwrite_in &&
    paddr_in == STATUS_CONTROL_OFFSET |-> !prdata_out[ACK_BIT]) else $error("ack read as one");
  chk_mask_withholds: assert property (acc && pwrite_in &&
    paddr_in == STATUS_CONTROL_OFFSET && pwdata_in[MASK_BIT] |=> ##1 !irq_request_out)
    else $error("masked request shown");
  chk_reset_clears: assert property (disable iff (1'b0)
    !resetn_in |=> !irq_request_out && irq_pullup_out) else $error("reset left state");
  chk_option_pads: assert property (acc && pwrite_in &&
    paddr_in == OPTION_CONTROL_OFFSET |=> ##1 irq_pullup_out ==
    !$past(pwdata_in[PULLUP_DISABLE_BIT], 2)) else $error("pullup not per option");
  cover property (acc && pwrite_in && pwdata_in[ACK_BIT]);
  cover property ($rose(irq_request_out));
  cover property (acc && !pwrite_in && paddr_in == OPTION_CONTROL_OFFSET);
endmodule
bind external_irq_latch external_irq_latch_checker chk_u (.*);

// *** verification/irq_source_model.sv ***
/* open-drain sources pulling the two interrupt pins low
   assumes pad pullup levels come from the design */
module irq_source_model (
  // clock
  input wire logic clk_in,
  // bit 0 dedicated pin, bit 1 shared pin
  input wire logic [1:0] pull_in,
  input wire logic [1:0] pullup_in,
  output logic [1:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drift = 1'b0;
  always @(posedge clk_in) drift <= !drift;
  assign pin_out = ~pull_in & (pullup_in | {2{drift}});
endmodule

// *** verification/test_external_irq_latch.sv ***
/* bench for external_irq_latch: apb tasks, pin sources, random writes
   assumes the checker binds itself from its own file */
module test_external_irq_latch
  import ext_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ST = STATUS_CONTROL_OFFSET;
  localparam logic [7:0] OP = OPTION_CONTROL_OFFSET;
  localparam logic [7:0] SY = SYSTEM_CONTROL_OFFSET;
  logic clk_in = '0, resetn_in = '0, psel_in = '0, penable_in = '0, pwrite_in = '0;
  logic vector_fetch_in = '0, break_state_in = '0, pready_out, pslverr_out, irq_request_out;
  logic irq_pullup_out, shared_pin_force_input_out, shared_pin_pullup_out;
  logic [7:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, prdata_out, rd_q;
  logic [15:0] vector_addr_out;
  logic [1:0] pull = '0;
  wire irq_n_in, shared_port_pin_in;
  int errors = 0, check_count = 0;
  external_irq_latch dut_u (.*);
  irq_source_model src_u (.clk_in(clk_in), .pull_in(pull),
    .pullup_in({shared_pin_pullup_out, irq_pullup_out}), .pin_out({shared_port_pin_in, irq_n_in}));
  initial forever #50 clk_in = ~clk_in;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd_q = prdata_out;
    {psel_in, penable_in} <= 2'b00;
    @(posedge clk_in);
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, g);
    chk_word(nm, 32'(e), 32'(g));
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk_word(nm, e, rd_q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // pins pass a synchroniser, so give them time to land
  task automatic pin(input logic [1:0] p);
    pull <= p;
    repeat (8) @(posedge clk_in);
  endtask
  function automatic logic [31:0] sx(input logic mo, ma, pe);
    return (32'(pe) << PENDING_BIT) | (32'(ma) << MASK_BIT) | (32'(mo) << MODE_BIT);
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    tally_and_finish;
  end
  initial begin
    logic [31:0] r;
    void'($urandom(32'hC1317845));
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd("st rst", ST, '0);
    rd("op rst", OP, '0);
    rd("sy rst", SY, '0);
    chk_bit("pullup", 1'b1, irq_pullup_out);
    wr(8'h24, '1);
    rd("unmapped", 8'h24, '0);
    pin(2'b01);
    rd("edge", ST, sx(0, 0, 1));
    chk_bit("req", 1'b1, irq_request_out);
    wr(ST, 32'h4);
    rd("ack", ST, '0);
    pin(2'b00);
    pin(2'b01);
    rd("edge2", ST, sx(0, 0, 1));
    vector_fetch_in <= 1'b1;
    @(posedge clk_in);
    vector_fetch_in <= 1'b0;
    rd("fetch", ST, '0);
    wr(ST, 32'h2);
    pin(2'b00);
    pin(2'b01);
    rd("masked", ST, sx(0, 1, 1));
    chk_bit("req m", 1'b0, irq_request_out);
    wr(ST, 32'h0);
    @(posedge clk_in);
    chk_bit("req u", 1'b1, irq_request_out);
    // level mode runs masked, as a service routine should
    wr(ST, 32'h3);
    pin(2'b00);
    pin(2'b01);
    wr(ST, 32'h7);
    rd("lvl low", ST, sx(1, 1, 1));
    pin(2'b00);
    rd("lvl ack1st", ST, sx(1, 1, 0));
    pin(2'b01);
    pin(2'b00);
    rd("lvl hold", ST, sx(1, 1, 1));
    wr(ST, 32'h7);
    rd("lvl clr", ST, sx(1, 1, 0));
    pin(2'b01);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd("rst low", ST, '0);
    repeat (8) @(posedge clk_in);
    rd("rst hold", ST, '0);
    pin(2'b00);
    wr(ST, 32'h4);
    pin(2'b01);
    break_state_in <= 1'b1;
    wr(ST, 32'h4);
    rd("brk hold", ST, sx(0, 0, 1));
    wr(SY, 32'h2);
    wr(ST, 32'h4);
    break_state_in <= 1'b0;
    rd("brk clr", ST, '0);
    wr(SY, '0);
    wr(OP, 32'h2);
    pin(2'b00);
    wr(ST, 32'h4);
    apb(1'b0, OP, '0);
    chk_bit("s input", 1'b1, shared_pin_force_input_out);
    chk_bit("s pullup", 1'b1, shared_pin_pullup_out);
    pin(2'b10);
    rd("s pend", ST, sx(0, 0, 1));
    rd("s flag", OP, 32'h6);
    rd("s rdclr", OP, 32'h2);
    wr(ST, 32'h4);
    wr(SY, 32'h1);
    pin(2'b00);
    pin(2'b10);
    rd("usb on", ST, '0);
    rd("usb flag", OP, 32'h2);
    wr(SY, '0);
    pin(2'b00);
    wr(OP, 32'h1);
    @(posedge clk_in);
    chk_bit("pud", 1'b0, irq_pullup_out);
    wr(OP, '0);
    pin(2'b00);
    wr(ST, 32'h4);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      wr(ST, r);
      rd("rand", ST, sx(r[MODE_BIT], r[MASK_BIT], 1'b0));
    end
    tally_and_finish;
  end
endmodule
